/* File: port_cfg_regs.svh */
/*
  Offsets, field layout and widths of the per-port configuration registers.
  Assumes it is included by bare name; definitions only.
*/
`ifndef PORT_CFG_REGS_SVH
`define PORT_CFG_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CHARGE_SUPPORT_OFFSET 8'h06
`define REMOVABLE_OFFSET 8'h07
`define PORT_USED_OFFSET 8'h08

// ----------------------------------------
// field layout
// ----------------------------------------
`define PORT_FIELD_MSB 3
`define PORT_FIELD_W 4
`define RSVD_FIELD_W 4
`define RSVD_READ_VALUE 4'h0
`define RSVD_FIELD_MSB 7
`define RSVD_FIELD_LSB 4
`define NO_PORTS 4'h0
`define PORT_FIELD_MASK 8'h0f
`define ADDR_W 8
`define DATA_W 8

`endif

/* File: port_cfg_pkg.sv */
/*
  Types shared by the per-port configuration register bank.
  Assumes port_cfg_regs.svh is compiled alongside.
*/
package port_cfg_pkg;
  // configuration source, gray coded along strap -> run
  typedef enum logic [1:0] {
    ST_STRAP = 2'h0,
    ST_RUN = 2'h1
  } cfg_state_t;
  typedef logic [3:0] port_mask_t;
endpackage

/* File: downstream_port_config_regs.sv */
/*
  Per-port configuration registers of a four-port hub: charging support,
  removable and port-used masks, loaded from straps at reset release and
  then writable by an EEPROM loader (I2C mode) or SMBus host (SMBus mode).
  Assumes a byte-wide synchronous register port from the configuration
  front end; all inputs synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "port_cfg_regs.svh"

// Functional notes
// - Bits 7:4 of all three registers ignore writes and read as zero.
// - Each charging support bit set to 1 means that port offers charging features.
// - Charging support bit n drives downstream port n.
// - Only charging bits of used ports may be replaced by EEPROM or host writes.
// - At reset release the charging field loads from the power-on/charge straps.
// - Each removable bit set to 1 reports that port's device as removable.
// - At reset release the removable field loads from the amber-LED straps.
// - Each port-used bit set to 1 marks that port as in use.
// - At reset release the port-used field loads from the green-LED straps.
// - I2C mode takes values from the EEPROM, SMBus mode from the SMBus host.
module downstream_port_config_regs (
  input wire logic clk_i, // core clock, 250 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic [3:0] power_on_charge_strap_i, // charge support straps
  input wire logic [3:0] amber_led_detachable_strap_i, // removable straps
  input wire logic [3:0] green_led_port_active_strap_i, // port-used straps
  input wire logic smbus_mode_i, // 1 = SMBus mode, 0 = I2C mode
  input wire logic eeprom_wr_i, // EEPROM loader write strobe
  input wire logic host_wr_i, // SMBus host write strobe
  input wire logic [7:0] wr_addr_i, // write register offset
  input wire logic [7:0] wr_data_i, // write data
  input wire logic [7:0] rd_addr_i, // read register offset
  output logic [7:0] rd_data_o, // registered read data
  output logic [3:0] charge_port_support_o, // per-port charging enable
  output logic [3:0] port_removable_o, // per-port removable flag
  output logic [3:0] port_used_o // per-port used flag
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  port_cfg_pkg::cfg_state_t state;
  port_cfg_pkg::port_mask_t charge_port_support;
  port_cfg_pkg::port_mask_t port_removable_config;
  port_cfg_pkg::port_mask_t port_used_config;
  logic wr_en;

  // ----------------------------------------
  // write source selection
  // ----------------------------------------
  // source follows mode
  assign wr_en = (state == port_cfg_pkg::ST_RUN)
    && (smbus_mode_i ? host_wr_i : eeprom_wr_i);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // straps are caught by the first clock after release, never under reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= port_cfg_pkg::ST_STRAP;
    else
      state <= port_cfg_pkg::ST_RUN;
  end

  // ----------------------------------------
  // charging support register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      charge_port_support <= '0;
    else if (state == port_cfg_pkg::ST_STRAP)
      charge_port_support <= power_on_charge_strap_i;
    else if (wr_en && hit(wr_addr_i, `CHARGE_SUPPORT_OFFSET))
      charge_port_support <= (wr_data_i[`PORT_FIELD_MSB:0] & port_used_config)
        | (charge_port_support & ~port_used_config);
  end

  // ----------------------------------------
  // removable register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_removable_config <= '0;
    else if (state == port_cfg_pkg::ST_STRAP)
      port_removable_config <= amber_led_detachable_strap_i;
    else if (wr_en && hit(wr_addr_i, `REMOVABLE_OFFSET))
      port_removable_config <= wr_data_i[`PORT_FIELD_MSB:0];
  end

  // ----------------------------------------
  // port used register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_used_config <= '0;
    else if (state == port_cfg_pkg::ST_STRAP)
      port_used_config <= green_led_port_active_strap_i;
    else if (wr_en && hit(wr_addr_i, `PORT_USED_OFFSET))
      port_used_config <= wr_data_i[`PORT_FIELD_MSB:0];
  end

  // ----------------------------------------
  // read port and outputs
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_data_o <= '0;
    else
    begin
      case (rd_addr_i)
        `CHARGE_SUPPORT_OFFSET: rd_data_o <= {`RSVD_READ_VALUE, charge_port_support};
        `REMOVABLE_OFFSET: rd_data_o <= {`RSVD_READ_VALUE, port_removable_config};
        `PORT_USED_OFFSET: rd_data_o <= {`RSVD_READ_VALUE, port_used_config};
        default: rd_data_o <= '0;
      endcase
    end
  end

  assign charge_port_support_o = charge_port_support;
  assign port_removable_o = port_removable_config;
  assign port_used_o = port_used_config;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // charge strap load
  property p_strap_charge;
    @(posedge clk_i) disable iff (rst_i)
    $fell(state == port_cfg_pkg::ST_STRAP) |->
      charge_port_support_o == $past(power_on_charge_strap_i);
  endproperty
  a_strap_charge: assert property (p_strap_charge)
    else $error("charge strap not loaded");

  property p_strap_rmb;
    @(posedge clk_i) disable iff (rst_i)
    $fell(state == port_cfg_pkg::ST_STRAP) |->
      port_removable_o == $past(amber_led_detachable_strap_i);
  endproperty
  a_strap_rmb: assert property (p_strap_rmb)
    else $error("removable strap not loaded");

  property p_strap_used;
    @(posedge clk_i) disable iff (rst_i)
    $fell(state == port_cfg_pkg::ST_STRAP) |->
      port_used_o == $past(green_led_port_active_strap_i);
  endproperty
  a_strap_used: assert property (p_strap_used)
    else $error("used strap not loaded");

  property p_unused_hold;
    @(posedge clk_i) disable iff (rst_i)
    state == port_cfg_pkg::ST_RUN ##1 state == port_cfg_pkg::ST_RUN |->
      ((charge_port_support_o ^ $past(charge_port_support_o)) & ~$past(port_used_o))
        == `NO_PORTS;
  endproperty
  a_unused_hold: assert property (p_unused_hold)
    else $error("unused charge bit changed");

  property p_rsvd_zero;
    @(posedge clk_i) disable iff (rst_i)
    rd_data_o[`RSVD_FIELD_MSB:`RSVD_FIELD_LSB] == `RSVD_READ_VALUE;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits not zero");

  property p_no_write_hold;
    @(posedge clk_i) disable iff (rst_i)
    state == port_cfg_pkg::ST_RUN && !wr_en |=> $stable(port_removable_o)
      && $stable(port_used_o) && $stable(charge_port_support_o);
  endproperty
  a_no_write_hold: assert property (p_no_write_hold)
    else $error("register changed unwritten");

  property p_mode_source;
    @(posedge clk_i) disable iff (rst_i)
    state == port_cfg_pkg::ST_RUN && smbus_mode_i && !host_wr_i
      && hit(wr_addr_i, `REMOVABLE_OFFSET) |=> $stable(port_removable_o);
  endproperty
  a_mode_source: assert property (p_mode_source)
    else $error("eeprom write in smbus mode");

  property p_used_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_en && hit(wr_addr_i, `PORT_USED_OFFSET) |=>
      {`NO_PORTS, port_used_o} == ($past(wr_data_i) & `PORT_FIELD_MASK);
  endproperty
  a_used_write: assert property (p_used_write)
    else $error("used write lost");

  property p_rmb_readback;
    @(posedge clk_i) disable iff (rst_i)
    rd_addr_i == `REMOVABLE_OFFSET |=>
      rd_data_o == {`RSVD_READ_VALUE, $past(port_removable_o)};
  endproperty
  a_rmb_readback: assert property (p_rmb_readback)
    else $error("removable readback wrong");

  property p_rmb_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_en && hit(wr_addr_i, `REMOVABLE_OFFSET) |=>
      {`NO_PORTS, port_removable_o} == ($past(wr_data_i) & `PORT_FIELD_MASK);
  endproperty
  a_rmb_write: assert property (p_rmb_write)
    else $error("removable write lost");

  property p_charge_write;
    @(posedge clk_i) disable iff (rst_i)
    wr_en && hit(wr_addr_i, `CHARGE_SUPPORT_OFFSET) |=>
      {`NO_PORTS, charge_port_support_o}
        == (($past(wr_data_i) & {`NO_PORTS, $past(port_used_o)})
          | {`NO_PORTS, $past(charge_port_support_o) & ~$past(port_used_o)});
  endproperty
  a_charge_write: assert property (p_charge_write)
    else $error("charge write wrong");

  property p_unmapped_read;
    @(posedge clk_i) disable iff (rst_i)
    !hit(rd_addr_i, `CHARGE_SUPPORT_OFFSET) && !hit(rd_addr_i, `REMOVABLE_OFFSET)
      && !hit(rd_addr_i, `PORT_USED_OFFSET) |=>
      rd_data_o == {`RSVD_READ_VALUE, `NO_PORTS};
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

endmodule

/* File: cfg_source_model.sv */
/*
  Configuration source model: EEPROM loader and SMBus host write strobes.
  Either strobe may be driven in either mode; the testbench also drives the source that the mode pin ignores.
*/
`timescale 1ns/1ps
module cfg_source_model (
  input wire logic clk_i, // core clock
  output logic eeprom_wr_o, // loader write strobe
  output logic host_wr_o, // host write strobe
  output logic [7:0] wr_addr_o, // write offset
  output logic [7:0] wr_data_o // write data
);
  initial
  begin
    eeprom_wr_o = 1'b0;
    host_wr_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 8'h00;
  end
  task automatic write_reg(input logic from_host, input logic [7:0] addr,
                           input logic [7:0] data);
    @(posedge clk_i);
    #1;
    host_wr_o = from_host;
    eeprom_wr_o = !from_host;
    wr_addr_o = addr;
    wr_data_o = data;
    @(posedge clk_i);
    #1;
    host_wr_o = 1'b0;
    eeprom_wr_o = 1'b0;
    // released bus shows inverted values, never the stale ones
    wr_addr_o = ~addr;
    wr_data_o = ~data;
  endtask
endmodule

/* File: testbench.sv */
/*
  Self-checking bench for the per-port configuration register bank.
  Assumes the design header and package are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  localparam logic [3:0] CHG = 4'ha;
  localparam logic [3:0] RMV = 4'h6;
  localparam logic [3:0] USD = 4'hc;
  logic clk_i, rst_i, smbus_mode, eeprom_wr, host_wr;
  logic [3:0] chg_strap, rmv_strap, usd_strap, charge, removable, used;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
  int failures = 0;
  int checks_done = 0;
  downstream_port_config_regs i_downstream_port_config_regs (.clk_i(clk_i), .rst_i(rst_i),
    .power_on_charge_strap_i(chg_strap), .amber_led_detachable_strap_i(rmv_strap),
    .green_led_port_active_strap_i(usd_strap), .smbus_mode_i(smbus_mode),
    .eeprom_wr_i(eeprom_wr), .host_wr_i(host_wr), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .charge_port_support_o(charge),
    .port_removable_o(removable), .port_used_o(used));
  cfg_source_model i_cfg_source_model (.clk_i(clk_i), .eeprom_wr_o(eeprom_wr),
    .host_wr_o(host_wr), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clk_i);
    #1;
    rd_addr = addr;
    @(posedge clk_i);
    #1;
    chk(rd_data, exp, "read data");
  endtask
  task automatic ports(input logic [3:0] c, input logic [3:0] r, input logic [3:0] u);
    chk({4'h0, charge}, {4'h0, c}, "charge mask");
    chk({4'h0, removable}, {4'h0, r}, "removable mask");
    chk({4'h0, used}, {4'h0, u}, "used mask");
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    #(600 * 4);
    failures++;
    stop_test();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst_i = 1'b1;
    smbus_mode = 1'b1;
    rd_addr = 8'h00;
    chg_strap = CHG;
    rmv_strap = RMV;
    usd_strap = USD;
    repeat (8) @(posedge clk_i);
    #1;
    ports(4'h0, 4'h0, 4'h0);
    chk(rd_data, 8'h00, "read data in reset");
    rst_i = 1'b0;
    @(posedge clk_i);
    #1;
    // later strap changes must not reach the registers
    chg_strap = ~CHG;
    rmv_strap = ~RMV;
    usd_strap = ~USD;
    rd(8'h06, {4'h0, CHG});
    rd(8'h07, {4'h0, RMV});
    rd(8'h08, {4'h0, USD});
    ports(CHG, RMV, USD);
    i_cfg_source_model.write_reg(1'b1, 8'h08, 8'hf5);
    rd(8'h08, 8'h05);
    i_cfg_source_model.write_reg(1'b0, 8'h08, 8'h0f);
    i_cfg_source_model.write_reg(1'b0, 8'h07, 8'h00);
    ports(CHG, RMV, 4'h5);
    i_cfg_source_model.write_reg(1'b1, 8'h06, 8'hff);
    ports((CHG & ~4'h5) | 4'h5, RMV, 4'h5);
    i_cfg_source_model.write_reg(1'b1, 8'h06, 8'h00);
    rd(8'h06, {4'h0, CHG & ~4'h5});
    i_cfg_source_model.write_reg(1'b1, 8'h09, 8'hff);
    rd(8'h09, 8'h00);
    ports(CHG & ~4'h5, RMV, 4'h5);
    smbus_mode = 1'b0;
    i_cfg_source_model.write_reg(1'b0, 8'h07, 8'h39);
    rd(8'h07, 8'h09);
    i_cfg_source_model.write_reg(1'b1, 8'h07, 8'h00);
    i_cfg_source_model.write_reg(1'b0, 8'h06, 8'hf5);
    ports((CHG & ~4'h5) | 4'h5, 4'h9, 4'h5);
    // second reset picks up the straps as they stand now
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    ports(4'h0, 4'h0, 4'h0);
    chk(rd_data, 8'h00, "read data in reset");
    rst_i = 1'b0;
    @(posedge clk_i);
    #1;
    ports(~CHG, ~RMV, ~USD);
    rd(8'h06, {4'h0, ~CHG});
    stop_test();
  end
endmodule
